// ### hdl/serial_unit.sv
// Clocked synchronous serial unit: 8-bit receive and transmit, LSB first.
// Assumes a single-cycle register port master on clk; pins are asynchronous.
`timescale 1ns/100ps
`include "serial_unit_map.svh"

module serial_unit
	import serial_unit_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [`SU_ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic serial_clock_pin_i,
	output logic serial_clock_pin_o,
	output logic serial_clock_pin_oe,
	input wire logic serial_rx_pin,
	output logic shared_port_pin_o,
	output logic shared_port_pin_oe,
	input wire logic shared_port_data
);

	// ------------------------------------------------------------------------
	// State and decoded controls
	// ------------------------------------------------------------------------
	su_state_t st_q;
	su_state_t st_d;
	reg_req_t req;
	logic sync_mode;
	logic rx_en;
	logic tx_en;
	logic ext_clk;
	logic cont_out;
	logic clk_run;
	logic rise_ev;
	logic fall_ev;
	logic rx_bit;
	logic rx_done;
	logic [7:0] rx_byte;
	logic tx_load;
	logic wr_tdr;
	logic wr_ssr;
	logic [1:0] cks;
	logic [`SU_DIV_W-1:0] half_period;

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// Mode and control decode.
	assign sync_mode = st_q.mode[`SU_MD_COM];
	assign rx_en = st_q.ctrl[`SU_CT_RE] & sync_mode;
	assign tx_en = st_q.ctrl[`SU_CT_TE] & sync_mode;
	assign ext_clk = st_q.ctrl[`SU_CT_CLOCK_SOURCE_HI];
	assign cont_out = ~ext_clk & st_q.ctrl[`SU_CT_CLOCK_SOURCE_LO];
	assign wr_tdr = req.wr && (req.addr == `SU_OFS_TX_HOLD);
	assign wr_ssr = req.wr && (req.addr == `SU_OFS_STATUS);

	// Internal clock select: three divider taps, the fourth code reuses the slowest.
	assign cks = (st_q.mode[1:0] == 2'h3) ? 2'h2 : st_q.mode[1:0];
	assign half_period = `SU_DIV_W'(({6'h00, st_q.bit_rate_divider} + 14'h0001) << {cks, 1'b0});

	// The internal clock idles high and runs while there is anything to move.
	assign clk_run = cont_out | rx_en | (tx_en & (st_q.tx_cnt != 4'h0 | ~st_q.tx_holding_empty));

	// Edge events come from the selected source; the pin is read only after sync.
	assign rise_ev = ext_clk ? (st_q.sck_s2 & ~st_q.sck_s3)
		: (~ext_clk & st_q.sck_int == 1'b0 && clk_run && st_q.div_cnt == 14'h0001);
	assign fall_ev = ext_clk ? (~st_q.sck_s2 & st_q.sck_s3)
		: (st_q.sck_int == 1'b1 && clk_run && st_q.div_cnt == 14'h0001);

	// Receive input passes optional inversion before the shifter sees it.
	assign rx_bit = st_q.rx_s2 ^ st_q.port_ctrl[`SU_PC_RX_INV];

	// Character completion on the eighth rising edge.
	assign rx_done = rx_en && rise_ev && (st_q.rx_cnt == `SU_RX_LAST);
	always_comb begin
		rx_byte = st_q.rx_shift;
		rx_byte[st_q.rx_cnt] = rx_bit;
	end

	// Reload happens at a falling edge when the shifter has sent its last bit.
	assign tx_load = tx_en && fall_ev && (st_q.tx_cnt <= 4'h1) && !st_q.tx_holding_empty;

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		// Two-stage synchronisers for the clock and receive pins.
		st_d.sck_s1 = serial_clock_pin_i;
		st_d.sck_s2 = st_q.sck_s1;
		st_d.sck_s3 = st_q.sck_s2;
		st_d.rx_s1 = serial_rx_pin;
		st_d.rx_s2 = st_q.rx_s1;

		// Internal clock divider, restarted whenever the clock is parked.
		if (!clk_run || ext_clk) begin
			st_d.div_cnt = half_period;
			st_d.sck_int = 1'b1;
		end else if (st_q.div_cnt <= 14'h0001) begin
			st_d.div_cnt = half_period;
			st_d.sck_int = ~st_q.sck_int;
		end else begin
			st_d.div_cnt = st_q.div_cnt - 14'h0001;
		end

		// Register writes; status bits only clear, so the data is ANDed in.
		if (req.wr) begin
			case (req.addr)
				`SU_OFS_PORT_CTRL: st_d.port_ctrl = req.wdata;
				`SU_OFS_MODE: st_d.mode = req.wdata;
				`SU_OFS_BRR: st_d.bit_rate_divider = req.wdata;
				`SU_OFS_CTRL: st_d.ctrl = req.wdata;
				`SU_OFS_TX_HOLD: begin
					st_d.tx_hold = req.wdata;
					st_d.tx_holding_empty = 1'b0;
				end
				`SU_OFS_STATUS: begin
					st_d.tx_holding_empty = st_q.tx_holding_empty & req.wdata[`SU_ST_TX_HOLDING_EMPTY];
					st_d.rx_holding_full = st_q.rx_holding_full & req.wdata[`SU_ST_RX_HOLDING_FULL];
					st_d.overrun_flag = st_q.overrun_flag & req.wdata[`SU_ST_OER];
					st_d.framing_error_flag = st_q.framing_error_flag & req.wdata[`SU_ST_FER];
					st_d.parity_error_flag = st_q.parity_error_flag & req.wdata[`SU_ST_PER];
				end
				default: begin
					// Receive holding and unmapped addresses ignore writes.
				end
			endcase
		end

		// Receive shifting; hardware set wins over a same-cycle clear.
		if (rx_en && rise_ev) begin
			st_d.rx_shift = rx_byte;
			st_d.rx_cnt = st_q.rx_cnt + 3'h1;
			if (rx_done) begin
				if (st_q.rx_holding_full) begin
					st_d.overrun_flag = 1'b1;
				end else begin
					st_d.rx_hold = rx_byte;
					st_d.rx_holding_full = 1'b1;
				end
				st_d.rx_shift = `SU_RST_BYTE;
			end
		end else if (!rx_en) begin
			st_d.rx_cnt = 3'h0;
		end

		// Transmit shifting: each bit is launched on a falling edge.
		if (tx_en && fall_ev) begin
			if (tx_load) begin
				st_d.tx_shift = st_q.tx_hold;
				st_d.txd = st_q.tx_hold[0];
				st_d.tx_cnt = `SU_CHAR_BITS;
				st_d.tx_holding_empty = 1'b1;
			end else if (st_q.tx_cnt > 4'h1) begin
				st_d.tx_shift = {1'b0, st_q.tx_shift[7:1]};
				st_d.txd = st_q.tx_shift[1];
				st_d.tx_cnt = st_q.tx_cnt - 4'h1;
			end else begin
				st_d.tx_cnt = 4'h0;
				st_d.txd = 1'b1;
			end
		end else if (tx_en && rise_ev && st_q.tx_cnt == 4'h1 && st_q.tx_holding_empty) begin
			// Nothing queued: the character ends at its last rising edge, so a parked
			// internal clock never shows a stray low pulse after the eighth bit.
			st_d.tx_cnt = 4'h0;
		end else if (!tx_en) begin
			st_d.tx_cnt = 4'h0;
			st_d.txd = 1'b1;
		end

		// Read data stands in the cycle after the read strobe.
		st_d.rd_data = `SU_RST_BYTE;
		if (req.rd) begin
			case (req.addr)
				`SU_OFS_PORT_CTRL: st_d.rd_data = st_q.port_ctrl;
				`SU_OFS_MODE: st_d.rd_data = st_q.mode;
				`SU_OFS_BRR: st_d.rd_data = st_q.bit_rate_divider;
				`SU_OFS_CTRL: st_d.rd_data = st_q.ctrl;
				`SU_OFS_TX_HOLD: st_d.rd_data = st_q.tx_hold;
				`SU_OFS_RX_HOLD: st_d.rd_data = st_q.rx_hold;
				`SU_OFS_STATUS: st_d.rd_data = {st_q.tx_holding_empty, st_q.rx_holding_full, st_q.overrun_flag,
					st_q.framing_error_flag, st_q.parity_error_flag, 3'h0};
				default: st_d.rd_data = `SU_RST_BYTE;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= '0;
			st_q.bit_rate_divider <= `SU_RST_BRR;
			st_q.tx_holding_empty <= 1'b1;
			st_q.txd <= 1'b1;
			st_q.sck_int <= 1'b1;
			st_q.sck_s1 <= 1'b1;
			st_q.sck_s2 <= 1'b1;
			st_q.sck_s3 <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs; the clock pin only drives for an internal source.
	assign reg_rdata = st_q.rd_data;
	assign serial_clock_pin_oe = ~ext_clk & sync_mode;
	assign serial_clock_pin_o = st_q.sck_int;
	assign shared_port_pin_o = st_q.port_ctrl[`SU_PC_TX_SEL] ? st_q.txd : shared_port_data;
	assign shared_port_pin_oe = 1'b1;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	sequence seq_done_while_full;
		rx_done && st_q.rx_holding_full;
	endsequence

	sequence seq_done_while_empty;
		rx_done && !st_q.rx_holding_full;
	endsequence

	AST_NO_FRAME_ERR: assert property (@(posedge clk) disable iff (!reset_n)
		!st_q.framing_error_flag && !st_q.parity_error_flag)
		else $error("Framing or parity flag set in synchronous operation.");

	AST_RX_TRANSFER: assert property (@(posedge clk) disable iff (!reset_n)
		seq_done_while_empty |=> st_q.rx_holding_full && st_q.rx_hold == $past(rx_byte)
			&& st_q.rx_cnt == 3'h0)
		else $error("Completed byte did not reach receive holding.");

	AST_RX_OVERRUN: assert property (@(posedge clk) disable iff (!reset_n)
		seq_done_while_full |=> st_q.overrun_flag && $stable(st_q.rx_hold))
		else $error("Overrun not flagged or holding contents lost.");

	AST_RX_HOLD_RO: assert property (@(posedge clk) disable iff (!reset_n)
		!rx_done |=> $stable(st_q.rx_hold))
		else $error("Receive holding changed without a completed byte.");

	AST_RX_LSB_FIRST: assert property (@(posedge clk) disable iff (!reset_n)
		rx_en && rise_ev && st_q.rx_cnt == 3'h0 |=> st_q.rx_shift[0] == $past(rx_bit))
		else $error("First received bit not placed at bit 0.");

	AST_TX_NO_RELOAD: assert property (@(posedge clk) disable iff (!reset_n)
		tx_en && fall_ev && st_q.tx_cnt <= 4'h1 && st_q.tx_holding_empty |=> st_q.tx_cnt == 4'h0)
		else $error("Transmit shifter reloaded with empty holding.");

	AST_TX_RELOAD: assert property (@(posedge clk) disable iff (!reset_n)
		tx_load |=> st_q.tx_holding_empty && st_q.tx_cnt == 4'h8 && st_q.txd == $past(st_q.tx_hold[0]))
		else $error("Transmit reload did not start the next character.");

	AST_TXD_ON_FALL: assert property (@(posedge clk) disable iff (!reset_n)
		!fall_ev && tx_en |=> $stable(st_q.txd))
		else $error("Transmit data changed away from a falling edge.");

	AST_FLAGS_NO_SET: assert property (@(posedge clk) disable iff (!reset_n)
		wr_ssr && !rx_done |=> !$rose(st_q.rx_holding_full) && !$rose(st_q.overrun_flag))
		else $error("Status write set a flag.");

	AST_RX_DISABLED: assert property (@(posedge clk) disable iff (!reset_n)
		!rx_en && !wr_ssr |=> $stable(st_q.rx_holding_full) && $stable(st_q.overrun_flag) ##0 $stable(st_q.rx_shift))
		else $error("Disabled receiver changed its state.");

	AST_EXT_CLK_IN: assert property (@(posedge clk) disable iff (!reset_n)
		ext_clk |-> !serial_clock_pin_oe)
		else $error("Clock pin driven with external source.");

	// A continuous internal clock output must toggle when its divider expires, not just be enabled.
	AST_CONT_CLK: assert property (@(posedge clk) disable iff (!reset_n)
		cont_out && sync_mode && !req.wr && st_q.div_cnt <= 14'h0001
			|=> serial_clock_pin_oe && st_q.sck_int != $past(st_q.sck_int))
		else $error("Continuous clock output not running.");

	AST_CLK_IDLE_HIGH: assert property (@(posedge clk) disable iff (!reset_n)
		!clk_run |=> serial_clock_pin_o)
		else $error("Parked internal clock did not rest high.");

	AST_ASYNC_IDLE: assert property (@(posedge clk) disable iff (!reset_n)
		!sync_mode && !req.wr |=> st_q.rx_cnt == 3'h0 && st_q.tx_cnt == 4'h0
			&& !serial_clock_pin_oe)
		else $error("Synchronous logic active in asynchronous mode.");

	// Receive path: sampling only on rising events, gating and input polarity.
	AST_RX_ON_RISE: assert property (@(posedge clk) disable iff (!reset_n)
		rx_en && !rise_ev |=> $stable(st_q.rx_shift) && $stable(st_q.rx_cnt))
		else $error("Receive shifter moved away from a rising edge.");

	AST_RX_GATED: assert property (@(posedge clk) disable iff (!reset_n)
		!st_q.ctrl[`SU_CT_RE] |=> st_q.rx_cnt == 3'h0)
		else $error("Receive bit counter ran with the receiver off.");

	AST_RX_INVERT: assert property (@(posedge clk) disable iff (!reset_n)
		st_q.port_ctrl[`SU_PC_RX_INV] |-> rx_bit != st_q.rx_s2)
		else $error("Receive input not inverted.");

	// Status view: the read byte mirrors the flags that were standing.
	AST_STATUS_FULL: assert property (@(posedge clk) disable iff (!reset_n)
		req.rd && req.addr == `SU_OFS_STATUS |=> reg_rdata[`SU_ST_RX_HOLDING_FULL] == $past(st_q.rx_holding_full))
		else $error("Status read did not show the receive-full flag.");

	AST_STATUS_OVERRUN: assert property (@(posedge clk) disable iff (!reset_n)
		req.rd && req.addr == `SU_OFS_STATUS |=> reg_rdata[`SU_ST_OER] == $past(st_q.overrun_flag))
		else $error("Status read did not show the overrun flag.");

	// Transmit path: a data write queues the byte; mid-character events move one bit.
	AST_TX_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
		wr_tdr && !tx_load |=> !st_q.tx_holding_empty && st_q.tx_hold == $past(req.wdata))
		else $error("Transmit data write did not queue the byte.");

	sequence seq_tx_mid_char;
		tx_en && fall_ev && !tx_load && st_q.tx_cnt > 4'h1;
	endsequence

	AST_TX_NEXT_BIT: assert property (@(posedge clk) disable iff (!reset_n)
		seq_tx_mid_char |=> st_q.txd == $past(st_q.tx_shift[1])
			&& st_q.tx_cnt == $past(st_q.tx_cnt) - 4'h1)
		else $error("Transmit shifter did not move to the next bit.");

	AST_SHARED_PIN: assert property (@(posedge clk) disable iff (!reset_n)
		shared_port_pin_oe && (st_q.port_ctrl[`SU_PC_TX_SEL] ? shared_port_pin_o == st_q.txd
			: shared_port_pin_o == shared_port_data))
		else $error("Shared pin shows the wrong source.");

endmodule : serial_unit

// ### shared/serial_unit_map.svh
// Register offsets, field positions and reset values of the clocked serial unit.
// Assumes a 16-bit byte address on the register port.
`ifndef SERIAL_UNIT_MAP_SVH
`define SERIAL_UNIT_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SU_ADDR_W 16
`define SU_OFS_PORT_CTRL 16'hFF91
`define SU_OFS_MODE 16'hFFA8
`define SU_OFS_BRR 16'hFFA9
`define SU_OFS_CTRL 16'hFFAA
`define SU_OFS_TX_HOLD 16'hFFAB
`define SU_OFS_STATUS 16'hFFAC
`define SU_OFS_RX_HOLD 16'hFFAD

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SU_PC_TX_SEL 5
`define SU_PC_RX_INV 2
`define SU_MD_COM 7
`define SU_MD_MP 2
`define SU_MD_CKS_HI 1
`define SU_MD_CKS_LO 0
`define SU_CT_TE 5
`define SU_CT_RE 4
`define SU_CT_CLOCK_SOURCE_HI 1
`define SU_CT_CLOCK_SOURCE_LO 0
`define SU_ST_TX_HOLDING_EMPTY 7
`define SU_ST_RX_HOLDING_FULL 6
`define SU_ST_OER 5
`define SU_ST_FER 4
`define SU_ST_PER 3

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define SU_RST_BYTE 8'h00
`define SU_RST_BRR 8'hFF
`define SU_CHAR_BITS 4'h8
`define SU_DIV_W 14
`define SU_RX_LAST 3'h7

`endif

// ### shared/serial_unit_pkg.sv
// Types of the clocked serial unit: register port request and whole-block state.
// Assumes serial_unit_map.svh supplies the address width.
`include "serial_unit_map.svh"

package serial_unit_pkg;

	// ------------------------------------------------------------------------
	// Register port request
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [`SU_ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	// ------------------------------------------------------------------------
	// Complete state of the unit
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] port_ctrl;
		logic [7:0] mode;
		logic [7:0] bit_rate_divider;
		logic [7:0] ctrl;
		logic [7:0] tx_hold;
		logic [7:0] rx_hold;
		logic [7:0] rx_shift;
		logic [7:0] tx_shift;
		logic tx_holding_empty;
		logic rx_holding_full;
		logic overrun_flag;
		logic framing_error_flag;
		logic parity_error_flag;
		logic [2:0] rx_cnt;
		logic [3:0] tx_cnt;
		logic txd;
		logic sck_int;
		logic [`SU_DIV_W-1:0] div_cnt;
		logic sck_s1;
		logic sck_s2;
		logic sck_s3;
		logic rx_s1;
		logic rx_s2;
		logic [7:0] rd_data;
	} su_state_t;

endpackage : serial_unit_pkg

// ### verification/serial_peer.sv
// External clocked serial peer: makes the transfer clock and receive data.
// Assumes frame is called from a process that runs just after a clk edge.
`timescale 1ns/100ps

module serial_peer (
	input wire logic clk,
	output logic sck,
	output logic rxd,
	input wire logic txd
);
	// ------------------------------------------------------------------------
	// Idle levels
	// ------------------------------------------------------------------------
	// The clock rests high outside frames, as an external master's would.
	initial begin
		sck = 1'b1;
		rxd = 1'b1;
	end

	// ------------------------------------------------------------------------
	// One character, 400 ns per bit
	// ------------------------------------------------------------------------
	// Data changes with the falling edge and is steady at the rising edge.
	// After the frame the line is turned over, so a stale bit never looks valid.
	task automatic frame(input logic [7:0] b, output logic [7:0] got);
		for (int i = 0; i < 8; i++) begin
			sck <= 1'b0;
			rxd <= b[i];
			repeat (4) @(posedge clk);
			sck <= 1'b1;
			repeat (2) @(posedge clk);
			got[i] = txd;
			repeat (2) @(posedge clk);
		end
		rxd <= ~b[7];
	endtask : frame
endmodule : serial_peer

// ### verification/serial_unit_tb.sv
// Self-checking bench of the clocked serial unit, register calls and peer frames.
// Assumes serial_peer drives the clock pin whenever the unit does not.
`timescale 1ns/100ps
`include "serial_unit_map.svh"

module serial_unit_tb;
	import serial_unit_pkg::*;

	// ------------------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------------------
	logic clk = 1'b0;
	logic reset_n;
	logic [`SU_ADDR_W-1:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_rdata;
	logic ck_o;
	logic ck_oe;
	logic peer_sck;
	logic peer_rxd;
	logic pin_o;
	logic pin_oe;
	logic port_data;
	logic [7:0] got;
	int errors = 0;
	int cmp_count = 0;
	int rises;

	// The clock pin is two-way: the unit wins while it drives it.
	wire logic ck_pin = ck_oe ? ck_o : peer_sck;

	// Half period of 25 ns gives the 20 MHz system clock.
	always #25 clk = ~clk;

	serial_unit i_serial_unit (
		.clk(clk),
		.reset_n(reset_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.serial_clock_pin_i(ck_pin),
		.serial_clock_pin_o(ck_o),
		.serial_clock_pin_oe(ck_oe),
		.serial_rx_pin(peer_rxd),
		.shared_port_pin_o(pin_o),
		.shared_port_pin_oe(pin_oe),
		.shared_port_data(port_data)
	);

	serial_peer i_serial_peer (
		.clk(clk),
		.sck(peer_sck),
		.rxd(peer_rxd),
		.txd(pin_o)
	);

	// ------------------------------------------------------------------------
	// Access and checking tasks
	// ------------------------------------------------------------------------
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so look there.
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask : rd

	// Flag latency is two synchroniser cycles plus one register.
	task automatic frame_settle(input logic [7:0] b);
		i_serial_peer.frame(b, got);
		repeat (4) @(posedge clk);
	endtask : frame_settle

	// Counts rising edges of the driven clock pin over a number of system cycles.
	task automatic count_rises(input int n);
		logic prev;
		rises = 0;
		prev = ck_o;
		repeat (n) begin
			@(posedge clk);
			#1;
			if (ck_o === 1'b1 && prev === 1'b0) begin
				rises++;
			end
			prev = ck_o;
		end
	endtask : count_rises

	task automatic tally_and_finish;
		$display("compares=%0d mismatches=%0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// ------------------------------------------------------------------------
	// Hang guard
	// ------------------------------------------------------------------------
	// A stuck sequence is cut off well inside the cycle budget.
	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		tally_and_finish;
	end

	// ------------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		reg_addr = '0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		port_data = 1'b0;
		repeat (20) @(posedge clk);
		reset_n <= 1'b1;
		rd(`SU_OFS_STATUS, 8'h80);
		rd(`SU_OFS_BRR, 8'hFF);
		rd(16'hFF00, 8'h00);
		wr(`SU_OFS_STATUS, 8'hFF);
		rd(`SU_OFS_STATUS, 8'h80);
		wr(`SU_OFS_RX_HOLD, 8'h5A);
		rd(`SU_OFS_RX_HOLD, 8'h00);
		$display("test reset_and_access done");
		// Synchronous mode, external clock, receive and transmit together.
		wr(`SU_OFS_MODE, 8'h80);
		wr(`SU_OFS_CTRL, 8'h32);
		wr(`SU_OFS_PORT_CTRL, 8'h20);
		rd(`SU_OFS_CTRL, 8'h32);
		// Bytes are not bit palindromes, so a reversed bit order cannot pass.
		wr(`SU_OFS_TX_HOLD, 8'h3A);
		rd(`SU_OFS_TX_HOLD, 8'h3A);
		rd(`SU_OFS_STATUS, 8'h00);
		frame_settle(8'hB4);
		chk(got, 8'h3A);
		rd(`SU_OFS_STATUS, 8'hC0);
		rd(`SU_OFS_RX_HOLD, 8'hB4);
		$display("test sync_transfer done");
		// A second character while still full overruns; no transmit reload.
		frame_settle(8'h96);
		chk(got, 8'hFF);
		rd(`SU_OFS_STATUS, 8'hE0);
		rd(`SU_OFS_RX_HOLD, 8'hB4);
		wr(`SU_OFS_STATUS, 8'h9F);
		rd(`SU_OFS_STATUS, 8'h80);
		$display("test overrun done");
		// Inverted input: the peer sends the complement.
		wr(`SU_OFS_PORT_CTRL, 8'h24);
		frame_settle(8'hA3);
		rd(`SU_OFS_RX_HOLD, 8'h5C);
		rd(`SU_OFS_STATUS, 8'hC0);
		$display("test invert done");
		// Receiver off: nothing shifts and the flags stay.
		wr(`SU_OFS_STATUS, 8'h9F);
		wr(`SU_OFS_CTRL, 8'h22);
		frame_settle(8'h11);
		rd(`SU_OFS_STATUS, 8'h80);
		rd(`SU_OFS_RX_HOLD, 8'h5C);
		$display("test rx_disabled done");
		// Continuous internal clock with the smallest practical divider.
		wr(`SU_OFS_BRR, 8'h01);
		wr(`SU_OFS_CTRL, 8'h01);
		count_rises(40);
		chk({7'h00, ck_oe}, 8'h01);
		chk({7'h00, (rises >= 9 && rises <= 11)}, 8'h01);
		// Second divider tap: a half period of 2<<2 cycles gives one rise per 16 cycles.
		wr(`SU_OFS_MODE, 8'h81);
		count_rises(64);
		chk({7'h00, (rises >= 3 && rises <= 5)}, 8'h01);
		wr(`SU_OFS_CTRL, 8'h02);
		repeat (2) @(posedge clk);
		chk({7'h00, ck_oe}, 8'h00);
		wr(`SU_OFS_MODE, 8'h00);
		wr(`SU_OFS_CTRL, 8'h01);
		repeat (2) @(posedge clk);
		chk({7'h00, ck_oe}, 8'h00);
		$display("test clock_source done");
		// General port use of the shared pin.
		wr(`SU_OFS_PORT_CTRL, 8'h00);
		for (int v = 0; v < 2; v++) begin
			port_data <= v[0];
			repeat (2) @(posedge clk);
			chk({6'h00, pin_oe, pin_o}, {6'h00, 1'b1, v[0]});
		end
		$display("test shared_pin done");
		tally_and_finish;
	end
endmodule : serial_unit_tb
